// *** logic/ebw_ext_bus_ctrl.sv ***
// External bus data width, segment address and chip select generation.
// Assumes CPU requests come from logic on i_clk; straps and pins are synchronised here.
//
// What this block does
// - 16-bit mode uses whole data port, 8-bit mode only the low byte.
// - Word on 8-bit bus runs as two byte cycles, low byte first, assembled internally.
// - On 16-bit bus upper byte selected by upper enable, lower byte by A0.
// - Split strobe mode: write pin is low-byte strobe, upper enable is high-byte strobe.
// - Byte write to 16-bit device drives the byte onto both data halves.
// - Byte read from 16-bit device keeps only the addressed byte.
// - Address port released for I/O unless some window is demultiplexed.
// - Upper byte enable pin works when disable bit is 0, else released.
// - Disable bit resets to 0 with 16-bit strap, otherwise to 1.
// - Segment line count follows the reset-latched select field.
// - Chip select count follows the reset-latched count field.
// - Each chip select goes low inside its window, high outside.
// - At each external cycle one chip select is chosen, all others driven high.
// - Internal accesses leave chip selects alone; extension peripheral access clears all.
// - Window without an enabled chip select deasserts every enabled line.
// - Chip select mode from write and read mode bits, address mode default.
// - Address mode asserts at latch-enable fall and holds until another area.
// - Read/write modes assert only while the matching strobe is active.
// - Boot chip select is active right after reset outside single chip mode.
// - Pull-ups hold chip selects high in reset, then enabled lines are driven.
// - During hold acknowledge pull-ups go on for enabled lines; new master drives.
`timescale 1ns/1ps
module ebw_ext_bus_ctrl (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// CPU request, byte data in bits 7:0
	input wire logic i_req,
	input wire logic i_write,
	input wire logic i_byte,
	input wire logic [23:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_internal,
	input wire logic i_xper,
	input wire logic [2:0] i_window,
	// Window configuration
	input wire logic [4:0] i_window_bus16,
	input wire logic [4:0] i_window_demux,
	input wire logic [4:0] i_chipsel_write_mode,
	input wire logic [4:0] i_chipsel_read_mode,
	input wire logic i_write_pin_config,
	input wire logic i_byte_dis_we,
	input wire logic i_byte_dis,
	// Reset straps
	input wire logic i_strap_bus16,
	input wire logic [1:0] i_strap_seg,
	input wire logic [1:0] i_strap_cs,
	input wire logic i_single_chip,
	// Pins in
	input wire logic [15:0] i_ext_data_port,
	input wire logic i_hold_ack_n,
	// CPU answer and status
	output logic o_busy,
	output logic o_done,
	output logic [15:0] o_rdata,
	output logic o_upper_byte_pin_disable,
	// Bus strobes
	output logic o_ale,
	output logic o_rd_n,
	output logic o_write_n,
	output logic o_upper_byte_enable_n,
	output logic o_upper_byte_enable_oe,
	// Data and address ports
	output logic [15:0] o_ext_data_port,
	output logic [1:0] o_ext_data_oe,
	output logic [15:0] o_ext_addr_port,
	output logic o_ext_addr_oe,
	output logic [6:0] o_seg_addr,
	output logic [6:0] o_seg_oe,
	// Chip selects
	output logic [3:0] o_chip_select_n,
	output logic [3:0] o_chip_select_oe,
	output logic [3:0] o_chip_select_pullup
);

	// ****************************************
	// Decoders
	// ****************************************
	function automatic logic [3:0] cs_mask_of(input logic [1:0] code);
		unique case (code)
			ebw_pkg::CS_FOUR: cs_mask_of = ebw_pkg::CS_MASK_FOUR;
			ebw_pkg::CS_NONE: cs_mask_of = ebw_pkg::CS_MASK_NONE;
			ebw_pkg::CS_TWO: cs_mask_of = ebw_pkg::CS_MASK_TWO;
			ebw_pkg::CS_THREE: cs_mask_of = ebw_pkg::CS_MASK_THREE;
		endcase
	endfunction

	function automatic logic [6:0] seg_mask_of(input logic [1:0] code);
		unique case (code)
			ebw_pkg::SEG_TWO: seg_mask_of = ebw_pkg::SEG_MASK_TWO;
			ebw_pkg::SEG_MAX: seg_mask_of = ebw_pkg::SEG_MASK_MAX;
			ebw_pkg::SEG_NONE: seg_mask_of = ebw_pkg::SEG_MASK_NONE;
			ebw_pkg::SEG_FOUR: seg_mask_of = ebw_pkg::SEG_MASK_FOUR;
		endcase
	endfunction

	// ****************************************
	// Synchronisers
	// ****************************************
	logic [5:0] strap_s;
	logic [16:0] pin_s;
	logic hold_act;
	logic [15:0] data_s;

	ebw_sync2 #(.W(ebw_pkg::STRAP_W)) u_strap_sync (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_async({i_single_chip, i_strap_cs, i_strap_seg, i_strap_bus16}),
		.o_sync(strap_s)
	);

	ebw_sync2 #(.W(17)) u_pin_sync (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_async({~i_hold_ack_n, i_ext_data_port}),
		.o_sync(pin_s)
	);

	assign hold_act = pin_s[16];
	assign data_s = pin_s[15:0];

	// ****************************************
	// Reset configuration latch
	// ****************************************
	logic [1:0] cfg_cnt;
	logic cfg_done;
	logic [1:0] seg_code;
	logic [1:0] cs_code;
	logic single_chip;
	logic byte_dis;
	logic [3:0] cs_mask;

	assign cs_mask = cs_mask_of(cs_code);

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cfg_cnt <= 2'h0;
			cfg_done <= 1'b0;
			seg_code <= ebw_pkg::SEG_TWO;
			cs_code <= ebw_pkg::CS_FOUR;
			single_chip <= 1'b0;
		end else if (!cfg_done) begin
			cfg_cnt <= cfg_cnt + 2'h1;
			if (cfg_cnt == ebw_pkg::STRAP_SETTLE) begin
				cfg_done <= 1'b1;
				seg_code <= strap_s[2:1];
				cs_code <= strap_s[4:3];
				single_chip <= strap_s[5];
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			byte_dis <= 1'b1;
		end else if (!cfg_done && cfg_cnt == ebw_pkg::STRAP_SETTLE) begin
			byte_dis <= ~strap_s[0];
		end else if (i_byte_dis_we) begin
			byte_dis <= i_byte_dis;
		end
	end

	// ****************************************
	// Cycle sequencer
	// ****************************************
	ebw_pkg::ebw_state_t state;
	logic [1:0] cmd_cnt;
	logic [23:0] cur_addr;
	logic [15:0] cur_wdata;
	logic cur_write;
	logic cur_byte;
	logic cur_bus16;
	logic cur_mux;
	logic [1:0] cur_mode;
	logic [3:0] cur_line;
	logic second;
	logic split_first;
	logic cmd_end;
	logic take;

	assign take = i_req && cfg_done && !hold_act && state == ebw_pkg::ST_IDLE;
	assign split_first = !cur_bus16 && !cur_byte && !second;
	assign cmd_end = state == ebw_pkg::ST_CMD && cmd_cnt == ebw_pkg::CMD_LAST;

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state <= ebw_pkg::ST_IDLE;
			cmd_cnt <= 2'h0;
			second <= 1'b0;
		end else begin
			unique case (state)
				ebw_pkg::ST_IDLE: begin
					if (take && !i_internal && !i_xper) begin
						state <= ebw_pkg::ST_ALE;
						second <= 1'b0;
					end
				end
				ebw_pkg::ST_ALE: begin
					state <= ebw_pkg::ST_CMD;
					cmd_cnt <= 2'h0;
				end
				ebw_pkg::ST_CMD: begin
					cmd_cnt <= cmd_cnt + 2'h1;
					if (cmd_end) begin
						if (split_first) begin
							state <= ebw_pkg::ST_ALE;
							second <= 1'b1;
						end else begin
							state <= ebw_pkg::ST_IDLE;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cur_addr <= 24'h000000;
			cur_wdata <= 16'h0000;
			cur_write <= 1'b0;
			cur_byte <= 1'b0;
			cur_bus16 <= 1'b0;
			cur_mux <= 1'b0;
			cur_mode <= ebw_pkg::CSM_ADDR;
			cur_line <= 4'h0;
		end else if (take) begin
			cur_addr <= i_addr;
			cur_wdata <= i_wdata;
			cur_write <= i_write;
			cur_byte <= i_byte;
			cur_bus16 <= i_window_bus16[i_window];
			cur_mux <= !i_window_demux[i_window];
			cur_mode <= {i_chipsel_write_mode[i_window], i_chipsel_read_mode[i_window]};
			cur_line <= (i_window < 3'h4) ? (4'h1 << i_window[1:0]) & cs_mask : 4'h0;
		end else if (cmd_end && split_first) begin
			cur_addr <= cur_addr + 24'h000001;
		end
	end

	// ****************************************
	// Read data assembly and answer
	// ****************************************
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_rdata <= 16'h0000;
			o_done <= 1'b0;
			o_busy <= 1'b0;
		end else begin
			o_done <= (take && (i_internal || i_xper)) || (cmd_end && !split_first);
			o_busy <= state != ebw_pkg::ST_IDLE || take;
			if (cmd_end && !cur_write) begin
				if (cur_bus16 && cur_byte) begin
					o_rdata <= {8'h00, cur_addr[0] ? data_s[15:8] : data_s[7:0]};
				end else if (cur_bus16) begin
					o_rdata <= data_s;
				end else if (second) begin
					o_rdata[15:8] <= data_s[7:0];
				end else begin
					o_rdata <= {8'h00, data_s[7:0]};
				end
			end
		end
	end

	// ****************************************
	// Chip select generation
	// ****************************************
	logic [3:0] cs_hold;
	logic [3:0] cs_strobe;
	logic strobe_match;

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cs_hold <= 4'h0;
		end else if (!cfg_done && cfg_cnt == ebw_pkg::STRAP_SETTLE) begin
			cs_hold <= strap_s[5] ? 4'h0 : ebw_pkg::CS_BOOT;
		end else if (take && i_xper) begin
			cs_hold <= 4'h0;
		end else if (state == ebw_pkg::ST_ALE) begin
			cs_hold <= (cur_mode == ebw_pkg::CSM_ADDR) ? cur_line : 4'h0;
		end
	end

	assign strobe_match = state == ebw_pkg::ST_CMD &&
		((cur_write && cur_mode[1]) || (!cur_write && cur_mode[0]));
	assign cs_strobe = strobe_match ? cur_line : 4'h0;

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_chip_select_n <= 4'hf;
			o_chip_select_oe <= 4'h0;
			o_chip_select_pullup <= ebw_pkg::CS_PULLUP_RST;
		end else if (!cfg_done) begin
			o_chip_select_n <= 4'hf;
			o_chip_select_oe <= 4'h0;
			o_chip_select_pullup <= ebw_pkg::CS_PULLUP_RST;
		end else begin
			o_chip_select_n <= ~((cs_hold | cs_strobe) & cs_mask & {4{~single_chip}});
			o_chip_select_oe <= hold_act ? 4'h0 : cs_mask;
			o_chip_select_pullup <= hold_act ? cs_mask : 4'h0;
		end
	end

	// ****************************************
	// Byte lane strobes and pins
	// ****************************************
	logic lo_sel;
	logic hi_sel;
	logic in_cmd;
	logic [7:0] wbyte;

	assign lo_sel = !cur_bus16 || !cur_byte || !cur_addr[0];
	assign hi_sel = cur_bus16 && (!cur_byte || cur_addr[0]);
	assign in_cmd = state == ebw_pkg::ST_CMD;
	assign wbyte = second ? cur_wdata[15:8] : cur_wdata[7:0];

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_ale <= 1'b0;
			o_rd_n <= 1'b1;
			o_write_n <= 1'b1;
			o_upper_byte_enable_n <= 1'b1;
			o_upper_byte_enable_oe <= 1'b0;
			o_upper_byte_pin_disable <= 1'b1;
		end else begin
			o_ale <= state == ebw_pkg::ST_ALE;
			o_rd_n <= !(in_cmd && !cur_write);
			o_upper_byte_pin_disable <= byte_dis;
			o_upper_byte_enable_oe <= !byte_dis;
			if (i_write_pin_config) begin
				o_write_n <= !(in_cmd && cur_write && lo_sel);
				o_upper_byte_enable_n <= !(in_cmd && cur_write && hi_sel);
			end else begin
				o_write_n <= !(in_cmd && cur_write);
				o_upper_byte_enable_n <= !(state != ebw_pkg::ST_IDLE && hi_sel);
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_ext_data_port <= 16'h0000;
			o_ext_data_oe <= 2'h0;
		end else if (state == ebw_pkg::ST_ALE && cur_mux) begin
			o_ext_data_port <= cur_addr[15:0];
			o_ext_data_oe <= cur_bus16 ? 2'h3 : 2'h1;
		end else if (in_cmd && cur_write) begin
			if (cur_bus16 && cur_byte) begin
				o_ext_data_port <= {cur_wdata[7:0], cur_wdata[7:0]};
			end else if (cur_bus16) begin
				o_ext_data_port <= cur_wdata;
			end else begin
				o_ext_data_port <= {8'h00, wbyte};
			end
			o_ext_data_oe <= cur_bus16 ? 2'h3 : 2'h1;
		end else begin
			o_ext_data_oe <= 2'h0;
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_ext_addr_port <= 16'h0000;
			o_ext_addr_oe <= 1'b0;
			o_seg_addr <= 7'h00;
			o_seg_oe <= 7'h00;
		end else begin
			o_ext_addr_port <= cur_addr[15:0];
			o_ext_addr_oe <= |i_window_demux;
			o_seg_addr <= cur_addr[ebw_pkg::SEG_LSB +: ebw_pkg::SEG_W];
			o_seg_oe <= cfg_done ? seg_mask_of(seg_code) : 7'h00;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	a_narrow_low_lane: assert property (
		in_cmd && cur_write && !cur_bus16 |=> o_ext_data_oe == 2'h1
	) else $error("narrow write drove the upper data lane");

	a_split_second_addr: assert property (
		cmd_end && split_first |=> state == ebw_pkg::ST_ALE && second && cur_addr == $past(cur_addr) + 24'h000001
	) else $error("split word did not start its second byte");

	a_upper_select: assert property (
		state == ebw_pkg::ST_ALE && cur_bus16 && !cur_byte && !i_write_pin_config |=> !o_upper_byte_enable_n
	) else $error("word access on wide bus left upper byte unselected");

	a_split_strobes: assert property (
		in_cmd && cur_write && cur_bus16 && cur_byte && cur_addr[0] && i_write_pin_config
		|=> !o_upper_byte_enable_n && o_write_n
	) else $error("high byte write used the wrong strobe");

	a_byte_mirror: assert property (
		in_cmd && cur_write && cur_bus16 && cur_byte |=> o_ext_data_port[15:8] == o_ext_data_port[7:0]
	) else $error("byte write not mirrored on both halves");

	a_bhe_release: assert property (
		byte_dis |=> !o_upper_byte_enable_oe && o_upper_byte_pin_disable
	) else $error("upper byte enable driven while disabled");

	a_unmapped_cs: assert property (
		state == ebw_pkg::ST_ALE && cur_line == 4'h0 |=> ##1 o_chip_select_n == 4'hf
	) else $error("chip select active for a window without a line");

	a_reset_pullup: assert property (
		!cfg_done |=> o_chip_select_pullup == 4'hf && o_chip_select_oe == 4'h0
	) else $error("chip selects not held by pull-ups before configuration");

	a_hold_pullup: assert property (
		cfg_done && hold_act |=> o_chip_select_pullup == $past(cs_mask) && o_chip_select_oe == 4'h0
	) else $error("hold acknowledge did not hand chip selects to pull-ups");

	a_cycle_length: assert property (
		state == ebw_pkg::ST_IDLE ##1 state == ebw_pkg::ST_ALE |=> in_cmd [*3] ##1 !in_cmd
	) else $error("command phase length wrong");

endmodule // ebw_ext_bus_ctrl

// *** include/ebw_pkg.sv ***
// Constants and types for the external bus width, segment and chip select block.
// Assumes a single 20 MHz core clock; no register bus, all settings are ports.
package ebw_pkg;

	// ****************************************
	// Clock and timing
	// ****************************************
	localparam int unsigned CLK_MHZ = 20;
	localparam int unsigned CMD_TIME_NS = 150;
	localparam int unsigned CMD_CYCLES = (CMD_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam logic [1:0] CMD_LAST = 2'(CMD_CYCLES - 1);
	localparam logic [1:0] STRAP_SETTLE = 2'h2;

	// ****************************************
	// Widths
	// ****************************************
	localparam int unsigned DATA_W = 16;
	localparam int unsigned ADDR_W = 24;
	localparam int unsigned SEG_W = 7;
	localparam int unsigned SEG_LSB = 16;
	localparam int unsigned CS_W = 4;
	localparam int unsigned WIN_N = 5;
	localparam int unsigned STRAP_W = 6;

	// ****************************************
	// Segment line select codes and masks
	// ****************************************
	localparam logic [1:0] SEG_TWO = 2'h3;
	localparam logic [1:0] SEG_MAX = 2'h2;
	localparam logic [1:0] SEG_NONE = 2'h1;
	localparam logic [1:0] SEG_FOUR = 2'h0;
	localparam logic [6:0] SEG_MASK_TWO = 7'h03;
	localparam logic [6:0] SEG_MASK_MAX = 7'h7f;
	localparam logic [6:0] SEG_MASK_NONE = 7'h00;
	localparam logic [6:0] SEG_MASK_FOUR = 7'h0f;

	// ****************************************
	// Chip select count codes and masks
	// ****************************************
	localparam logic [1:0] CS_FOUR = 2'h3;
	localparam logic [1:0] CS_NONE = 2'h2;
	localparam logic [1:0] CS_TWO = 2'h1;
	localparam logic [1:0] CS_THREE = 2'h0;
	localparam logic [3:0] CS_MASK_FOUR = 4'hf;
	localparam logic [3:0] CS_MASK_NONE = 4'h0;
	localparam logic [3:0] CS_MASK_TWO = 4'h3;
	localparam logic [3:0] CS_MASK_THREE = 4'h7;

	// ****************************************
	// Chip select modes, {write_mode, read_mode}
	// ****************************************
	localparam logic [1:0] CSM_ADDR = 2'h0;
	localparam logic [1:0] CSM_READ = 2'h1;
	localparam logic [1:0] CSM_WRITE = 2'h2;
	localparam logic [1:0] CSM_RW = 2'h3;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [3:0] CS_PULLUP_RST = 4'hf;
	localparam logic [3:0] CS_BOOT = 4'h1;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_ALE = 3'b010,
		ST_CMD = 3'b100
	} ebw_state_t;

endpackage

// *** logic/ebw_sync2.sv ***
// Two flip-flop synchroniser for pins that arrive from outside the clock domain.
// Assumes each bit is an independent level; no word coherency is given.
`timescale 1ns/1ps
module ebw_sync2 #(
	parameter int unsigned W = 1
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// Levels
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);

	logic [W-1:0] meta;

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			meta <= '0;
			o_sync <= '0;
		end else begin
			meta <= i_async;
			o_sync <= meta;
		end
	end

endmodule // ebw_sync2

// *** tb/ebw_mem_model.sv ***
// Behavioural byte or word wide external memory on the data, strobe and address pins.
// Assumes the bench tells it the bus width and strobe wiring of the window in use.
`timescale 1ns/1ps
module ebw_mem_model (
	// Clock
	input wire logic i_clk,
	// Bus pins
	input wire logic i_ale,
	input wire logic i_rd_n,
	input wire logic i_write_n,
	input wire logic i_ube_n,
	input wire logic [15:0] i_dout,
	input wire logic [15:0] i_addr_port,
	input wire logic i_addr_oe,
	// Wiring of the memory
	input wire logic i_bus16,
	input wire logic i_split,
	output logic [15:0] o_din
);
	// ********
	// Storage and pins
	// ********
	logic [7:0] mem [256];
	logic [7:0] lat = 8'h00;
	logic [15:0] last = 16'h0000;
	logic act = 1'b0;
	logic was_rd = 1'b0;
	logic wl;
	logic wh;
	logic [7:0] cur;
	initial begin
		for (int i = 0; i < 256; i++) mem[i] = 8'h00;
	end
	assign wl = i_bus16 ? (!i_write_n && (i_split || !lat[0])) : !i_write_n;
	assign wh = i_bus16 && (i_split ? !i_ube_n : (!i_write_n && !i_ube_n));
	// Undriven lanes toggle every cycle so stale data never passes for a match
	// Address decoded during the latch pulse so data stands two edges before the core takes it
	assign cur = !i_ale ? lat : i_addr_oe ? i_addr_port[7:0] : i_dout[7:0];
	assign o_din = !(act || i_ale) ? ~last : i_bus16 ? {mem[cur | 8'h01], mem[cur & 8'hfe]} : {~last[15:8], mem[cur]};
	always @(posedge i_clk) begin
		last <= o_din;
		was_rd <= !i_rd_n;
		if (i_ale) begin
			lat <= i_addr_oe ? i_addr_port[7:0] : i_dout[7:0];
			act <= 1'b1;
		end else if ((was_rd && i_rd_n) || !i_write_n) begin
			act <= 1'b0;
		end
		if (wl) mem[i_bus16 ? (lat & 8'hfe) : lat] <= i_dout[7:0];
		if (wh) mem[lat | 8'h01] <= i_dout[15:8];
	end
endmodule // ebw_mem_model

// *** tb/tb.sv ***
// Self-checking bench for the external bus width, segment and chip select block.
// Assumes the memory model on the pins and a 20 MHz clock; inputs change on the falling edge.
`timescale 1ns/1ps
module tb;
	// ********
	// Signals
	// ********
	logic i_clk = 1'b0, i_reset_n = 1'b0, i_req = 1'b0, i_write = 1'b0, i_byte = 1'b0;
	logic i_internal = 1'b0, i_xper = 1'b0, i_write_pin_config = 1'b0, i_byte_dis_we = 1'b0, i_byte_dis = 1'b0;
	logic i_strap_bus16 = 1'b1, i_single_chip = 1'b0, i_hold_ack_n = 1'b1;
	logic [1:0] i_strap_seg = 2'h3, i_strap_cs = 2'h3;
	logic [2:0] i_window = 3'h0;
	logic [4:0] i_window_bus16 = 5'h15, i_window_demux = 5'h00, i_chipsel_write_mode = 5'h00;
	logic [4:0] i_chipsel_read_mode = 5'h00;
	logic [23:0] i_addr = 24'h000000, ra;
	logic [15:0] i_wdata = 16'h0000, seed = 16'h0026, r, rd, wr_seen;
	wire [15:0] i_ext_data_port;
	logic o_busy, o_done, o_upper_byte_pin_disable, o_ale, o_rd_n, o_write_n, o_upper_byte_enable_n;
	logic o_upper_byte_enable_oe, o_ext_addr_oe, cs_seen, ube_seen, done_ok, rw, rb;
	logic [15:0] o_rdata, o_ext_data_port, o_ext_addr_port;
	logic [1:0] o_ext_data_oe, oe_seen;
	logic [6:0] o_seg_addr, o_seg_oe;
	logic [3:0] o_chip_select_n, o_chip_select_oe, o_chip_select_pullup;
	logic [2:0] rwin;
	logic [7:0] sh [256];
	int err_count = 0, tests_run = 0;

	always #25 i_clk = ~i_clk;

	ebw_ext_bus_ctrl i_dut (.i_clk, .i_reset_n, .i_req, .i_write, .i_byte, .i_addr, .i_wdata, .i_internal, .i_xper,
		.i_window, .i_window_bus16, .i_window_demux, .i_chipsel_write_mode, .i_chipsel_read_mode,
		.i_write_pin_config, .i_byte_dis_we, .i_byte_dis, .i_strap_bus16, .i_strap_seg, .i_strap_cs,
		.i_single_chip, .i_ext_data_port, .i_hold_ack_n, .o_busy, .o_done, .o_rdata, .o_upper_byte_pin_disable,
		.o_ale, .o_rd_n, .o_write_n, .o_upper_byte_enable_n, .o_upper_byte_enable_oe, .o_ext_data_port,
		.o_ext_data_oe, .o_ext_addr_port, .o_ext_addr_oe, .o_seg_addr, .o_seg_oe, .o_chip_select_n,
		.o_chip_select_oe, .o_chip_select_pullup);

	ebw_mem_model i_mem (.i_clk, .i_ale(o_ale), .i_rd_n(o_rd_n), .i_write_n(o_write_n),
		.i_ube_n(o_upper_byte_enable_oe ? o_upper_byte_enable_n : 1'b1), .i_dout(o_ext_data_port),
		.i_addr_port(o_ext_addr_port), .i_addr_oe(o_ext_addr_oe), .i_bus16(i_window_bus16[i_window]),
		.i_split(i_write_pin_config), .o_din(i_ext_data_port));

	// ********
	// Helpers
	// ********
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [6:0] seg_mask(input logic [1:0] c);
		return (c == 2'h3) ? 7'h03 : (c == 2'h2) ? 7'h7f : (c == 2'h1) ? 7'h00 : 7'h0f;
	endfunction
	function automatic logic [3:0] cs_mask(input logic [1:0] c);
		return (c == 2'h3) ? 4'hf : (c == 2'h2) ? 4'h0 : (c == 2'h1) ? 4'h3 : 4'h7;
	endfunction
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic do_reset(input logic [1:0] k);
		@(negedge i_clk);
		{i_reset_n, i_strap_seg, i_strap_cs, i_strap_bus16, i_single_chip} = {1'b0, k, k, k[0], k == 2'h0};
		repeat (4) @(negedge i_clk);
		check({4'h0, o_chip_select_pullup, o_chip_select_oe, o_chip_select_n}, 16'h0f0f, "reset pins");
		i_reset_n = 1'b1;
		repeat (5) @(negedge i_clk);
		check({9'h000, o_seg_oe}, {9'h000, seg_mask(k)}, "segment lines");
		check({12'h000, o_chip_select_oe}, {12'h000, cs_mask(k)}, "chip select lines");
		check({15'h0000, o_upper_byte_pin_disable}, {15'h0000, !k[0]}, "disable bit");
		check({8'h00, o_chip_select_pullup, o_chip_select_n | ~cs_mask(k)},
			{12'h000, ~(cs_mask(k) & {3'h0, k != 2'h0})}, "boot select");
	endtask
	task automatic access(input logic w, b, input logic [23:0] a, input logic [15:0] d, input logic [2:0] win,
		input logic [1:0] kind);
		@(negedge i_clk);
		{i_req, i_write, i_byte, i_addr, i_wdata, i_window, i_internal, i_xper} = {1'b1, w, b, a, d, win, kind};
		{cs_seen, ube_seen, done_ok, oe_seen} = 5'h00;
		@(negedge i_clk);
		{i_req, i_internal, i_xper} = 3'h0;
		for (int n = 0; n < 12 && !done_ok; n++) begin
			@(posedge i_clk);
			#1;
			cs_seen |= (win < 3'h4) && (o_chip_select_n[win[1:0]] === 1'b0);
			ube_seen |= (o_upper_byte_enable_oe === 1'b1);
			oe_seen |= o_ext_data_oe;
			if (o_write_n === 1'b0) wr_seen = o_ext_data_port;
			if (o_done === 1'b1) {done_ok, rd} = {1'b1, o_rdata};
		end
		if (done_ok && w && kind == 2'h0) begin
			if (b) sh[a[7:0]] = d[7:0];
			else {sh[a[7:0] | 8'h01], sh[a[7:0] & 8'hfe]} = d;
		end
	endtask

	// ********
	// Sequence
	// ********
	initial begin
		// Run is under 1000 cycles; the 20000-cycle limit leaves over twenty times that
		#1000000;
		err_count++;
		results();
	end
	initial begin
		for (int i = 0; i < 256; i++) sh[i] = 8'h00;
		for (int k = 0; k < 4; k++) do_reset(2'(k));
		check({15'h0000, o_ext_addr_oe}, 16'h0000, "address port free");
		i_window_demux = 5'h02;
		repeat (3) @(negedge i_clk);
		check({15'h0000, o_ext_addr_oe}, 16'h0001, "address port used");
		$display("reset and strap tests done");
		for (int i = 0; i < 60; i++) begin
			r = lfsr(seed);
			seed = lfsr(r);
			rwin = (r[2:0] > 3'h4) ? {1'b0, r[1:0]} : r[2:0];
			{rb, rw} = r[4:3];
			ra = {r[15:8], 8'h00, 4'h0, r[7:5], rb & r[10]};
			access(rw, rb, ra, seed, rwin, 2'h0);
			check({15'h0000, done_ok}, 16'h0001, "access done");
			if (!rw) check(rb ? {8'h00, rd[7:0]} : rd,
				rb ? {8'h00, sh[ra[7:0]]} : {sh[ra[7:0] | 8'h01], sh[ra[7:0]]}, "read data");
			if (rw && rb && i_window_bus16[rwin]) check(wr_seen, {seed[7:0], seed[7:0]}, "byte lanes");
			if (!i_window_bus16[rwin]) check({15'h0000, oe_seen[1]}, 16'h0000, "upper lane idle");
			check({9'h000, o_seg_addr}, {9'h000, ra[22:16]}, "segment address");
			check({12'h000, o_chip_select_n}, {12'h000, (rwin == 3'h4) ? 4'hf : ~(4'h1 << rwin)},
				"chip select");
		end
		$display("random access tests done");
		access(1'b0, 1'b0, 24'h000010, 16'h0000, 3'h1, 2'h0);
		access(1'b0, 1'b0, 24'h000010, 16'h0000, 3'h3, 2'h2);
		check({12'h000, o_chip_select_n}, 16'h000d, "internal keeps");
		access(1'b0, 1'b0, 24'h000010, 16'h0000, 3'h3, 2'h1);
		repeat (2) @(negedge i_clk);
		check({12'h000, o_chip_select_n}, 16'h000f, "extension clears");
		for (int m = 0; m < 4; m++) begin
			{i_chipsel_write_mode[2], i_chipsel_read_mode[2]} = 2'(m);
			for (int w = 0; w < 2; w++) begin
				access(1'(w), 1'b0, 24'h000020, 16'h5aa5, 3'h2, 2'h0);
				check({15'h0000, cs_seen}, {15'h0000, m == 0 || (w == 1 ? m[1] : m[0])}, "strobe");
				repeat (2) @(negedge i_clk);
				check({15'h0000, o_chip_select_n[2]}, {15'h0000, m != 0}, "after cycle");
			end
		end
		$display("chip select mode tests done");
		i_write_pin_config = 1'b1;
		access(1'b1, 1'b1, 24'h000031, 16'h00c3, 3'h0, 2'h0);
		access(1'b1, 1'b1, 24'h000030, 16'h003c, 3'h0, 2'h0);
		access(1'b0, 1'b0, 24'h000030, 16'h0000, 3'h0, 2'h0);
		check(rd, 16'hc33c, "split strobes");
		check({15'h0000, ube_seen}, 16'h0001, "upper enable on");
		@(negedge i_clk);
		{i_byte_dis_we, i_byte_dis} = 2'h3;
		@(negedge i_clk);
		i_byte_dis_we = 1'b0;
		access(1'b0, 1'b0, 24'h000030, 16'h0000, 3'h0, 2'h0);
		check({14'h0000, o_upper_byte_pin_disable, ube_seen}, 16'h0002, "upper enable off");
		$display("strobe and upper enable tests done");
		@(negedge i_clk);
		i_hold_ack_n = 1'b0;
		repeat (5) @(negedge i_clk);
		check({8'h00, o_chip_select_pullup, o_chip_select_oe}, 16'h00f0, "hold pull-ups");
		access(1'b0, 1'b0, 24'h000030, 16'h0000, 3'h0, 2'h0);
		check({15'h0000, done_ok}, 16'h0000, "hold refuses");
		check({15'h0000, o_busy}, 16'h0000, "hold leaves idle");
		@(negedge i_clk);
		i_hold_ack_n = 1'b1;
		repeat (5) @(negedge i_clk);
		check({8'h00, o_chip_select_pullup, o_chip_select_oe}, 16'h000f, "hold over");
		$display("bus hold tests done");
		results();
	end
endmodule // tb
